// ### irqfe_consts.svh
`ifndef IRQFE_CONSTS_SVH
`define IRQFE_CONSTS_SVH

// ----------------------------------------------------------------------
// Register word indexes
// ----------------------------------------------------------------------
`define IRQFE_ADDR_FLAG4   8'h00
`define IRQFE_ADDR_EN0     8'h01
`define IRQFE_ADDR_EN1     8'h02
`define IRQFE_ADDR_EN2     8'h03
`define IRQFE_ADDR_EN3     8'h04
`define IRQFE_ADDR_EN4     8'h05
`define IRQFE_ADDR_PRI4    8'h06
`define IRQFE_ADDR_ISTAT   8'h07
`define IRQFE_ADDR_IMASK   8'h08

// ----------------------------------------------------------------------
// Implemented bit masks
// ----------------------------------------------------------------------
`define IRQFE_MASK_FLAG4   16'h210E
`define IRQFE_MASK_EN0     16'h3FEF
`define IRQFE_MASK_EN1     16'hFE1F
`define IRQFE_MASK_EN2     16'h22E3
`define IRQFE_MASK_EN3     16'h4006
`define IRQFE_MASK_PRI4    16'h7FFF
`define IRQFE_MASK_SRC     16'h001F

// ----------------------------------------------------------------------
// Field positions of the group-four sources and the priority field width
// ----------------------------------------------------------------------
`define IRQFE_POS_CHARGE   13
`define IRQFE_POS_LOWV     8
`define IRQFE_POS_CRC      3
`define IRQFE_POS_UARTB    2
`define IRQFE_POS_UARTA    1
`define IRQFE_PRI_W        3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IRQFE_RST_REG      16'h0000
`define IRQFE_RST_PRI4     16'h4924

`endif

// ### irqfe_pkg.sv
package irqfe_pkg;

    // Group-four sources, one bit each
    typedef struct packed {
        logic charge_time;
        logic low_voltage;
        logic crc_gen;
        logic uart_b_error;
        logic uart_a_error;
    } irqfe_src_t;

    // Enable words handed to the other flag groups
    typedef struct packed {
        logic [15:0] group_three;
        logic [15:0] group_two;
        logic [15:0] group_one;
        logic [15:0] group_zero;
    } irqfe_allow_t;

endpackage

// ### irqfe_bank.sv
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "irqfe_consts.svh"

module irqfe_bank (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic [7:0]              reg_addr,
    input  wire logic [15:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [15:0]                  reg_rdata,
    input  wire irqfe_pkg::irqfe_src_t   src_event,
    output irqfe_pkg::irqfe_src_t        src_request,
    output irqfe_pkg::irqfe_allow_t      allow,
    output logic                         irq
);
    import irqfe_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] flag4_q;
    logic [15:0] flag4_d;
    logic [15:0] en0_q;
    logic [15:0] en0_d;
    logic [15:0] en1_q;
    logic [15:0] en1_d;
    logic [15:0] en2_q;
    logic [15:0] en2_d;
    logic [15:0] en3_q;
    logic [15:0] en3_d;
    logic [15:0] en4_q;
    logic [15:0] en4_d;
    logic [15:0] pri4_q;
    logic [15:0] pri4_d;
    logic [15:0] istat_q;
    logic [15:0] istat_d;
    logic [15:0] imask_q;
    logic [15:0] imask_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic [4:0]  req_q;
    logic [4:0]  req_d;
    logic        irq_q;
    logic        irq_d;

    logic [15:0] set_vec;
    logic [4:0]  ev_vec;
    logic [4:0]  src_flag;
    logic [4:0]  src_en;
    logic [4:0]  pri_live;

    // ------------------------------------------------------------------
    // Source mapping
    // ------------------------------------------------------------------
    assign ev_vec = src_event;

    always_comb begin
        set_vec = 16'h0000;
        set_vec[`IRQFE_POS_CHARGE] = src_event.charge_time;
        set_vec[`IRQFE_POS_LOWV]   = src_event.low_voltage;
        set_vec[`IRQFE_POS_CRC]    = src_event.crc_gen;
        set_vec[`IRQFE_POS_UARTB]  = src_event.uart_b_error;
        set_vec[`IRQFE_POS_UARTA]  = src_event.uart_a_error;
    end

    assign src_flag = {flag4_q[`IRQFE_POS_CHARGE], flag4_q[`IRQFE_POS_LOWV],
                       flag4_q[`IRQFE_POS_CRC], flag4_q[`IRQFE_POS_UARTB],
                       flag4_q[`IRQFE_POS_UARTA]};
    assign src_en   = {en4_q[`IRQFE_POS_CHARGE], en4_q[`IRQFE_POS_LOWV],
                       en4_q[`IRQFE_POS_CRC], en4_q[`IRQFE_POS_UARTB],
                       en4_q[`IRQFE_POS_UARTA]};

    // Priority fields: source i in bits 3i+2..3i
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_pri
            assign pri_live[gi] = |pri4_q[gi*`IRQFE_PRI_W +: `IRQFE_PRI_W];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        flag4_d = flag4_q;
        en0_d   = en0_q;
        en1_d   = en1_q;
        en2_d   = en2_q;
        en3_d   = en3_q;
        en4_d   = en4_q;
        pri4_d  = pri4_q;
        istat_d = istat_q;
        imask_d = imask_q;
        rdata_d = 16'h0000;
        if (reg_wr) begin
            unique case (reg_addr)
                `IRQFE_ADDR_FLAG4: flag4_d = reg_wdata & `IRQFE_MASK_FLAG4;
                `IRQFE_ADDR_EN0:   en0_d = reg_wdata & `IRQFE_MASK_EN0;
                `IRQFE_ADDR_EN1:   en1_d = reg_wdata & `IRQFE_MASK_EN1;
                `IRQFE_ADDR_EN2:   en2_d = reg_wdata & `IRQFE_MASK_EN2;
                `IRQFE_ADDR_EN3:   en3_d = reg_wdata & `IRQFE_MASK_EN3;
                `IRQFE_ADDR_EN4:   en4_d = reg_wdata & `IRQFE_MASK_FLAG4;
                `IRQFE_ADDR_PRI4:  pri4_d = reg_wdata & `IRQFE_MASK_PRI4;
                `IRQFE_ADDR_ISTAT: istat_d = istat_q & ~reg_wdata;
                `IRQFE_ADDR_IMASK: imask_d = reg_wdata & `IRQFE_MASK_SRC;
                default: ;
            endcase
        end
        // Hardware set wins over a clearing write in the same cycle
        flag4_d = flag4_d | set_vec;
        istat_d = istat_d | {11'h000, ev_vec};
        if (reg_rd) begin
            unique case (reg_addr)
                `IRQFE_ADDR_FLAG4: rdata_d = flag4_q;
                `IRQFE_ADDR_EN0:   rdata_d = en0_q;
                `IRQFE_ADDR_EN1:   rdata_d = en1_q;
                `IRQFE_ADDR_EN2:   rdata_d = en2_q;
                `IRQFE_ADDR_EN3:   rdata_d = en3_q;
                `IRQFE_ADDR_EN4:   rdata_d = en4_q;
                `IRQFE_ADDR_PRI4:  rdata_d = pri4_q;
                `IRQFE_ADDR_ISTAT: rdata_d = istat_q;
                `IRQFE_ADDR_IMASK: rdata_d = imask_q;
                default:           rdata_d = 16'h0000;
            endcase
        end
        req_d = src_flag & src_en & pri_live;
        irq_d = |(istat_q & imask_q);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flag4_q <= `IRQFE_RST_REG;
            en0_q   <= `IRQFE_RST_REG;
            en1_q   <= `IRQFE_RST_REG;
            en2_q   <= `IRQFE_RST_REG;
            en3_q   <= `IRQFE_RST_REG;
            en4_q   <= `IRQFE_RST_REG;
            pri4_q  <= `IRQFE_RST_PRI4;
            istat_q <= `IRQFE_RST_REG;
            imask_q <= `IRQFE_RST_REG;
            rdata_q <= `IRQFE_RST_REG;
            req_q   <= 5'h00;
            irq_q   <= 1'b0;
        end else begin
            flag4_q <= flag4_d;
            en0_q   <= en0_d;
            en1_q   <= en1_d;
            en2_q   <= en2_d;
            en3_q   <= en3_d;
            en4_q   <= en4_d;
            pri4_q  <= pri4_d;
            istat_q <= istat_d;
            imask_q <= imask_d;
            rdata_q <= rdata_d;
            req_q   <= req_d;
            irq_q   <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Enables are exported as written; routing an external pin first is left to software
    assign allow.group_zero  = en0_q;
    assign allow.group_one   = en1_q;
    assign allow.group_two   = en2_q;
    assign allow.group_three = en3_q;
    assign src_request       = req_q;
    assign reg_rdata         = rdata_q;
    assign irq               = irq_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_CRC_FLAG_SETS: assert property (
        src_event.crc_gen |=> flag4_q[3]
    ) else $error("crc event did not set bit 3");

    AST_FLAG_STICKY: assert property (
        (flag4_q[13] && !(reg_wr && reg_addr == `IRQFE_ADDR_FLAG4)) |=> flag4_q[13]
    ) else $error("pending flag dropped without a write");

    AST_SET_BEATS_CLEAR: assert property (
        (reg_wr && reg_addr == `IRQFE_ADDR_FLAG4 && reg_wdata == 16'h0000 && src_event.low_voltage)
        |=> flag4_q[8]
    ) else $error("clearing write lost a same-cycle event");

    AST_UNIMPL_ZERO: assert property (
        ((flag4_q & ~`IRQFE_MASK_FLAG4) == 16'h0000) && ((en1_q & ~`IRQFE_MASK_EN1) == 16'h0000)
        && ((en2_q & ~`IRQFE_MASK_EN2) == 16'h0000) && ((en0_q & ~`IRQFE_MASK_EN0) == 16'h0000)
        && ((en3_q & ~`IRQFE_MASK_EN3) == 16'h0000) && ((en4_q & ~`IRQFE_MASK_FLAG4) == 16'h0000)
    ) else $error("unassigned bit holds a one");

    AST_EN0_WRITE: assert property (
        (reg_wr && reg_addr == `IRQFE_ADDR_EN0) |=> en0_q == ($past(reg_wdata) & 16'h3FEF)
    ) else $error("group zero enable write wrong");

    AST_EN1_WRITE: assert property (
        (reg_wr && reg_addr == `IRQFE_ADDR_EN1) |=> allow.group_one == ($past(reg_wdata) & 16'hFE1F)
    ) else $error("group one enable write wrong");

    AST_EN2_WRITE: assert property (
        (reg_wr && reg_addr == `IRQFE_ADDR_EN2) |=> allow.group_two == ($past(reg_wdata) & 16'h22E3)
    ) else $error("group two enable write wrong");

    AST_EN3_WRITE: assert property (
        (reg_wr && reg_addr == `IRQFE_ADDR_EN3) |=> allow.group_three == ($past(reg_wdata) & 16'h4006)
    ) else $error("group three enable write wrong");

    AST_EN_READBACK: assert property (
        (reg_rd && reg_addr == `IRQFE_ADDR_EN0) |=> reg_rdata == $past(en0_q)
    ) else $error("enable readback wrong");

    AST_RESET_CLEARS: assert property (
        @(posedge clk) disable iff (1'b0)
        !reset_n |=> (flag4_q == 16'h0000 && allow == '0 && src_request == '0)
    ) else $error("reset left state set");

    AST_PRI_ZERO_BLOCKS: assert property (
        (pri4_q[14:12] == 3'h0) |=> !src_request.charge_time
    ) else $error("zero priority source requested");

    AST_REQUEST_CAUSE: assert property (
        src_request.crc_gen == $past(flag4_q[3] && en4_q[3] && (pri4_q[8:6] != 3'h0))
    ) else $error("request does not follow flag, enable and priority");

    AST_IRQ_FOLLOWS: assert property (
        (src_event.uart_a_error && imask_q[0] && !(reg_wr && reg_addr == `IRQFE_ADDR_IMASK))
        |=> ##1 irq
    ) else $error("unmasked event raised no interrupt");

endmodule // irqfe_bank

// ### irqfe_src_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Peripheral source model
// ----------------------------------------
module irqfe_src_model (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire irqfe_pkg::irqfe_src_t kick,
    output irqfe_pkg::irqfe_src_t      src_event
);
    import irqfe_pkg::*;
    // Each kicked source answers one cycle later with an event that lasts as long as its kick
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            src_event <= '0;
        end else begin
            src_event <= kick;
        end
    end
endmodule // irqfe_src_model

// ### tb_irq_flag_enable_bank.sv
`timescale 1ns/1ps
`include "irqfe_consts.svh"
module tb_irq_flag_enable_bank;
    import irqfe_pkg::*;
    logic         clk;
    logic         reset_n;
    logic [7:0]   reg_addr;
    logic [15:0]  reg_wdata;
    logic         reg_wr;
    logic         reg_rd;
    logic [15:0]  reg_rdata;
    irqfe_src_t   kick;
    irqfe_src_t   src_event;
    irqfe_src_t   src_request;
    irqfe_allow_t allow;
    logic         irq;
    int           n_mismatch;
    int           samples_checked;
    logic [15:0]  mask_tab [5];
    int           pos_tab [5];

    irqfe_bank DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
        .src_request(src_request), .allow(allow), .irq(irq));
    irqfe_src_model u_src (.clk(clk), .reset_n(reset_n), .kick(kick), .src_event(src_event));

    always #5 clk = ~clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Event pulse, then the request two edges after it
    task automatic fire(input int i, input logic er, input logic ei);
        @(posedge clk);
        kick <= irqfe_src_t'(5'h01 << i);
        @(posedge clk);
        kick <= '0;
        @(posedge clk);
        #1;
        check("request early", 16'h0000, {11'h000, src_request});
        @(posedge clk);
        #1;
        check("request", {11'h000, (5'(er) << i)}, {11'h000, src_request});
        check("irq", {15'h0000, ei}, {15'h0000, irq});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [15:0] d;
        for (int k = 0; k < 5; k++) begin
            rd(8'(k), d);
            check("reset word", 16'h0000, d);
            if (k < 4) check("reset allow", 16'h0000, allow[16*k +: 16]);
        end
        check("reset irq", 16'h0000, {15'h0000, irq});
    endtask

    task automatic t_regs();
        logic [15:0] d;
        for (int k = 0; k < 5; k++) begin
            wr(8'(k), 16'hFFFF);
            rd(8'(k), d);
            check("written word", mask_tab[k], d);
            if (k > 0) check("allow word", mask_tab[k], allow[16*(k-1) +: 16]);
            wr(8'(k), 16'h0000);
            rd(8'(k), d);
            check("cleared word", 16'h0000, d);
        end
        wr(8'h40, 16'hFFFF);
        rd(8'h40, d);
        check("unmapped word", 16'h0000, d);
    endtask

    task automatic t_events();
        logic [15:0] d;
        logic [15:0] b;
        for (int i = 0; i < 5; i++) begin
            b = 16'h0001 << pos_tab[i];
            wr(`IRQFE_ADDR_PRI4, 16'h7FFF);
            wr(`IRQFE_ADDR_EN4, 16'h0000);
            wr(`IRQFE_ADDR_IMASK, 16'h0001 << i);
            fire(i, 1'b0, 1'b1);
            rd(`IRQFE_ADDR_FLAG4, d);
            check("flag word", b, d);
            wr(`IRQFE_ADDR_ISTAT, 16'h001F);
            wr(`IRQFE_ADDR_IMASK, 16'h0000);
            #1;
            check("irq cleared", 16'h0000, {15'h0000, irq});
            wr(`IRQFE_ADDR_EN4, b);
            @(posedge clk);
            #1;
            check("sticky request", {11'h000, (5'h01 << i)}, {11'h000, src_request});
            wr(`IRQFE_ADDR_FLAG4, 16'h0000);
            @(posedge clk);
            #1;
            check("request dropped", 16'h0000, {11'h000, src_request});
            fire(i, 1'b1, 1'b0);
            wr(`IRQFE_ADDR_FLAG4, 16'h0000);
            wr(`IRQFE_ADDR_PRI4, 16'h7FFF & ~(16'h0007 << (3 * i)));
            fire(i, 1'b0, 1'b0);
            wr(`IRQFE_ADDR_FLAG4, 16'h0000);
            wr(`IRQFE_ADDR_ISTAT, 16'h001F);
        end
    endtask

    // Event and clearing write land on the same edge: the event must win
    task automatic t_race();
        logic [15:0] d;
        for (int r = 0; r < 2; r++) begin
            @(posedge clk);
            kick <= irqfe_src_t'(5'h08);
            @(posedge clk);
            kick <= '0;
            reg_addr <= (r == 0) ? `IRQFE_ADDR_FLAG4 : `IRQFE_ADDR_ISTAT;
            reg_wdata <= (r == 0) ? 16'h0000 : 16'h001F;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
            rd((r == 0) ? `IRQFE_ADDR_FLAG4 : `IRQFE_ADDR_ISTAT, d);
            check("set beats clear", (r == 0) ? (16'h0001 << `IRQFE_POS_LOWV) : 16'h0008, d);
        end
        wr(`IRQFE_ADDR_FLAG4, 16'h0000);
        wr(`IRQFE_ADDR_ISTAT, 16'h001F);
    endtask

    // Reset in mid-run with live state must bring the flag, enable and priority words back
    task automatic t_mid_reset();
        logic [15:0] d;
        wr(`IRQFE_ADDR_EN0, 16'hFFFF);
        wr(`IRQFE_ADDR_EN4, 16'hFFFF);
        wr(`IRQFE_ADDR_FLAG4, 16'hFFFF);
        wr(`IRQFE_ADDR_PRI4, 16'h7FFF);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            rd(8'(k), d);
            check("reset again", (k == 6) ? `IRQFE_RST_PRI4 : `IRQFE_RST_REG, d);
        end
        check("reset request", 16'h0000, {11'h000, src_request});
        check("reset allow", 16'h0000, allow.group_zero);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        kick = '0;
        n_mismatch = 0;
        samples_checked = 0;
        mask_tab = '{16'h210E, 16'h3FEF, 16'hFE1F, 16'h22E3, 16'h4006};
        pos_tab = '{1, 2, 3, 8, 13};
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_regs();
        t_events();
        t_race();
        t_mid_reset();
        results();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results();
    end
endmodule // tb_irq_flag_enable_bank
